// ===== ppc_path_decode.v
// playback path decoding from the stored control fields
`timescale 1ns/1ps
`include "ppc_regs.vh"
module ppc_path_decode (
  // clock and control
  input wire clk_sys,
  input wire reset,
  input wire clk_en,
  // stored fields
  input wire [1:0] mode,
  input wire pin_assign,
  input wire origin,
  input wire [4:0] level,
  input wire [2:0] hpf,
  input wire [7:0] pcm_vol,
  // decoded controls
  output reg amp_active,
  output reg amp_mute,
  output reg amp_shutdown,
  output reg pdm_in_playback,
  output reg pdm_in_sensor,
  output reg path_is_pdm,
  output reg [4:0] amp_level,
  output reg hpf_enable,
  output reg [2:0] hpf_corner,
  output reg pcm_vol_mute,
  output reg [7:0] pcm_atten
);
  // ---------------------------------------------------------------
  // registered decode
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (reset) begin
      amp_active <= 1'b0;
      amp_mute <= 1'b0;
      amp_shutdown <= 1'b1;
      pdm_in_playback <= 1'b0;
      pdm_in_sensor <= 1'b1;
      path_is_pdm <= 1'b0;
      amp_level <= 5'h10;
      hpf_enable <= 1'b1;
      hpf_corner <= 3'h1;
      pcm_vol_mute <= 1'b0;
      pcm_atten <= 8'h00;
    end else if (clk_en) begin
      // reserved mode code treated as shutdown
      amp_active <= (mode == `PPC_MODE_ACTIVE);
      amp_mute <= (mode == `PPC_MODE_MUTE);
      amp_shutdown <= (mode != `PPC_MODE_ACTIVE) && (mode != `PPC_MODE_MUTE);
      pdm_in_playback <= pin_assign;
      pdm_in_sensor <= ~pin_assign;
      path_is_pdm <= origin;
      // reserved level codes clamp to the top step
      amp_level <= (level > `PPC_LEVEL_MAX) ? `PPC_LEVEL_MAX : level;
      // filter only on pcm path, reserved code bypasses
      hpf_enable <= ~origin && (hpf != `PPC_HPF_BYPASS) && (hpf != `PPC_HPF_RESERVED);
      hpf_corner <= hpf;
      // volume only on pcm path
      pcm_vol_mute <= ~origin && (pcm_vol > `PPC_VOL_MAX_ATTEN);
      pcm_atten <= origin ? 8'h00 : pcm_vol;
    end
  end
endmodule // ppc_path_decode

// ===== ppc_power_ctrl_regs.v
// control register bank for amplifier mode, source, level, filter and pcm volume
// Contract
// - mode 00 active, 01 mute, 10 shutdown
// - current sense powered down when bit set
// - voltage sense powered down when bit set
// - pin assign bit: sensor 0, playback 1
// - pdm playback takes pin chosen by assign
// - source bit selects pcm 0, pdm 1
// - five-bit output level, reset 10h
// - three-bit highpass corner, reset 001b
// - highpass filter acts on pcm only
// - pcm volume, C9h upward mutes
// - pcm volume applies to pcm only
// - bank visible only in book 0, page 0
`timescale 1ns/1ps
`include "ppc_regs.vh"
module ppc_power_ctrl_regs (
  // clock and reset
  input wire clk_sys,
  input wire reset,
  input wire clk_en,
  // control port register access
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_hit,
  // sense power
  output wire current_sense_powerdown,
  output wire voltage_sense_powerdown,
  // decoded playback controls
  output wire amp_active,
  output wire amp_mute,
  output wire amp_shutdown,
  output wire first_pdm_data_in_playback,
  output wire first_pdm_data_in_sensor,
  output wire path_is_pdm,
  output wire [4:0] amp_level,
  output wire hpf_enable,
  output wire [2:0] highpass_corner,
  output wire pcm_vol_mute,
  output wire [7:0] pcm_atten
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  reg [7:0] page_sel_r;
  reg [7:0] book_sel_r;
  reg [7:0] power_mode_control_r;
  reg [7:0] playback_source_level_r;
  reg [7:0] highpass_corner_select_r;
  reg [7:0] pcm_volume_control_r;
  wire bank_sel;
  reg [7:0] rdata_nxt;
  reg hit_nxt;

  // bank addressable only in book 0 page 0
  assign bank_sel = (book_sel_r == 8'h00) && (page_sel_r == 8'h00);

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (reset) begin
      page_sel_r <= `PPC_PAGE_SEL_RST;
      book_sel_r <= `PPC_BOOK_SEL_RST;
      power_mode_control_r <= `PPC_POWER_MODE_CONTROL_RST;
      playback_source_level_r <= `PPC_PLAYBACK_SOURCE_LEVEL_RST;
      highpass_corner_select_r <= `PPC_HIGHPASS_CORNER_SELECT_RST;
      pcm_volume_control_r <= `PPC_PCM_VOLUME_CONTROL_RST;
    end else if (clk_en && reg_wr) begin
      // page and book selectors live on every page
      if (reg_addr == `PPC_PAGE_SEL_ADDR) begin
        page_sel_r <= reg_wdata;
      end
      if (reg_addr == `PPC_BOOK_SEL_ADDR) begin
        book_sel_r <= reg_wdata;
      end
      if (bank_sel) begin
        case (reg_addr)
          `PPC_POWER_MODE_CONTROL_ADDR: begin
            power_mode_control_r <= reg_wdata;
          end
          `PPC_PLAYBACK_SOURCE_LEVEL_ADDR: begin
            playback_source_level_r <= reg_wdata;
          end
          `PPC_HIGHPASS_CORNER_SELECT_ADDR: begin
            highpass_corner_select_r <= reg_wdata;
          end
          `PPC_PCM_VOLUME_CONTROL_ADDR: begin
            pcm_volume_control_r <= reg_wdata;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux, all bits read back as written
  // ---------------------------------------------------------------
  always @* begin
    rdata_nxt = 8'h00;
    hit_nxt = 1'b1;
    if (reg_addr == `PPC_PAGE_SEL_ADDR) begin
      rdata_nxt = page_sel_r;
    end else if (reg_addr == `PPC_BOOK_SEL_ADDR) begin
      rdata_nxt = book_sel_r;
    end else if (!bank_sel) begin
      hit_nxt = 1'b0;
    end else begin
      case (reg_addr)
        `PPC_POWER_MODE_CONTROL_ADDR: rdata_nxt = power_mode_control_r;
        `PPC_PLAYBACK_SOURCE_LEVEL_ADDR: rdata_nxt = playback_source_level_r;
        `PPC_HIGHPASS_CORNER_SELECT_ADDR: rdata_nxt = highpass_corner_select_r;
        `PPC_PCM_VOLUME_CONTROL_ADDR: rdata_nxt = pcm_volume_control_r;
        default: hit_nxt = 1'b0;
      endcase
    end
  end

  // registered read data, one cycle after the strobe
  always @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
      reg_hit <= (reg_rd || reg_wr) ? hit_nxt : 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sense power straight from stored bits
  // ---------------------------------------------------------------
  assign current_sense_powerdown = power_mode_control_r[`PPC_ISNS_BIT];
  assign voltage_sense_powerdown = power_mode_control_r[`PPC_VSNS_BIT];

  // pdm origin bit kept but not used: only the assigned pin feeds playback
  ppc_path_decode u_decode (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .mode(power_mode_control_r[`PPC_MODE_MSB:`PPC_MODE_LSB]),
    .pin_assign(playback_source_level_r[`PPC_PIN_ASSIGN_BIT]),
    .origin(playback_source_level_r[`PPC_ORIGIN_BIT]),
    .level(playback_source_level_r[`PPC_LEVEL_MSB:`PPC_LEVEL_LSB]),
    .hpf(highpass_corner_select_r[`PPC_HPF_MSB:`PPC_HPF_LSB]),
    .pcm_vol(pcm_volume_control_r),
    .amp_active(amp_active),
    .amp_mute(amp_mute),
    .amp_shutdown(amp_shutdown),
    .pdm_in_playback(first_pdm_data_in_playback),
    .pdm_in_sensor(first_pdm_data_in_sensor),
    .path_is_pdm(path_is_pdm),
    .amp_level(amp_level),
    .hpf_enable(hpf_enable),
    .hpf_corner(highpass_corner),
    .pcm_vol_mute(pcm_vol_mute),
    .pcm_atten(pcm_atten)
  );
endmodule // ppc_power_ctrl_regs

// ===== ppc_regs.vh
// register offsets, field positions and reset values of the playback power control bank
`ifndef PPC_REGS_VH
`define PPC_REGS_VH
// ---------------------------------------------------------------
// page select and offsets
// ---------------------------------------------------------------
`define PPC_PAGE_SEL_ADDR 8'h00
`define PPC_BOOK_SEL_ADDR 8'h7f
`define PPC_PAGE_SEL_RST 8'h00
`define PPC_BOOK_SEL_RST 8'h00
`define PPC_POWER_MODE_CONTROL_ADDR 8'h02
`define PPC_PLAYBACK_SOURCE_LEVEL_ADDR 8'h03
`define PPC_HIGHPASS_CORNER_SELECT_ADDR 8'h04
`define PPC_PCM_VOLUME_CONTROL_ADDR 8'h05
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PPC_POWER_MODE_CONTROL_RST 8'h0e
`define PPC_PLAYBACK_SOURCE_LEVEL_RST 8'h10
`define PPC_HIGHPASS_CORNER_SELECT_RST 8'h01
`define PPC_PCM_VOLUME_CONTROL_RST 8'h00
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PPC_MODE_LSB 0
`define PPC_MODE_MSB 1
`define PPC_VSNS_BIT 2
`define PPC_ISNS_BIT 3
`define PPC_LEVEL_LSB 0
`define PPC_LEVEL_MSB 4
`define PPC_ORIGIN_BIT 5
`define PPC_PDM_ORIGIN_BIT 6
`define PPC_PIN_ASSIGN_BIT 7
`define PPC_HPF_LSB 0
`define PPC_HPF_MSB 2
// ---------------------------------------------------------------
// codes
// ---------------------------------------------------------------
`define PPC_MODE_ACTIVE 2'h0
`define PPC_MODE_MUTE 2'h1
`define PPC_MODE_SHUTDOWN 2'h2
`define PPC_LEVEL_MAX 5'h14
`define PPC_HPF_BYPASS 3'h0
`define PPC_HPF_RESERVED 3'h7
`define PPC_VOL_MAX_ATTEN 8'hc8
`endif

// ===== ppc_regs_props.sv
// checker for access answers and decoded playback controls
`timescale 1ns/1ps
module ppc_regs_props (
  // clock and access
  input logic clk_sys, reset, clk_en, reg_wr, reg_rd,
  input logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input logic reg_hit,
  // decoded controls
  input logic current_sense_powerdown, voltage_sense_powerdown, amp_active, amp_mute, amp_shutdown,
  input logic path_is_pdm, first_pdm_data_in_playback, hpf_enable, pcm_vol_mute,
  input logic [4:0] amp_level,
  input logic [2:0] highpass_corner,
  input logic [7:0] pcm_atten
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // accepted write to one address
  sequence s_wr(logic [7:0] a);
    clk_en && reg_wr && reg_addr == a ##1 clk_en && reg_hit;
  endsequence
  a_mode_decode: assert property (s_wr(8'h02) ##1 1 |-> amp_active == ($past(reg_wdata[1:0], 2) == 2'h0)
    && amp_mute == ($past(reg_wdata[1:0], 2) == 2'h1) && amp_shutdown == $past(reg_wdata[1], 2))
    else $error("mode decode wrong");
  a_sense_pd: assert property (s_wr(8'h02) |-> current_sense_powerdown == $past(reg_wdata[3])
    && voltage_sense_powerdown == $past(reg_wdata[2])) else $error("sense powerdown wrong");
  a_source_map: assert property (s_wr(8'h03) ##1 1 |-> path_is_pdm == $past(reg_wdata[5], 2)
    && first_pdm_data_in_playback == $past(reg_wdata[7], 2)) else $error("source map wrong");
  a_level_clamp: assert property (s_wr(8'h03) ##1 1 |-> amp_level ==
    ($past(reg_wdata[4:0], 2) > 5'h14 ? 5'h14 : $past(reg_wdata[4:0], 2))) else $error("level wrong");
  a_hpf_pcm_only: assert property (hpf_enable |-> !path_is_pdm && highpass_corner != 3'h0
    && highpass_corner != 3'h7) else $error("filter enable wrong");
  a_vol_mute: assert property (pcm_vol_mute |-> !path_is_pdm && pcm_atten > 8'hc8)
    else $error("volume mute wrong");
  a_pdm_no_atten: assert property (path_is_pdm |-> pcm_atten == 8'h00 && !pcm_vol_mute)
    else $error("pcm volume on pdm path");
  a_select_hit: assert property (clk_en && (reg_wr || reg_rd) && reg_addr inside {8'h00, 8'h7f} |=> reg_hit)
    else $error("selector not answered");
  a_unmapped_quiet: assert property (clk_en && (reg_wr || reg_rd) && reg_addr > 8'h05 && reg_addr < 8'h7f
    |=> !reg_hit && reg_rdata == 8'h00) else $error("unmapped answered");
  a_frozen_hold: assert property (!clk_en |=> $stable(reg_rdata) && $stable(reg_hit)
    && $stable(current_sense_powerdown) && $stable(voltage_sense_powerdown) && $stable(amp_level)
    && $stable(pcm_atten)) else $error("state moved while frozen");
endmodule // ppc_regs_props
bind ppc_power_ctrl_regs ppc_regs_props ppc_regs_props_inst (.*);

// ===== tb_top.sv
// testbench for the playback power control register bank
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, v;
  wire [7:0] reg_rdata, pcm_atten;
  wire [4:0] amp_level;
  wire [2:0] highpass_corner;
  wire current_sense_powerdown, voltage_sense_powerdown, amp_active, amp_mute, amp_shutdown, reg_hit;
  wire first_pdm_data_in_playback, first_pdm_data_in_sensor, path_is_pdm, hpf_enable, pcm_vol_mute;
  wire [7:0] flags = {amp_active, amp_mute, amp_shutdown, current_sense_powerdown, voltage_sense_powerdown,
    path_is_pdm, first_pdm_data_in_playback, first_pdm_data_in_sensor};
  // pdm origin bit kept clear, reserved for software
  logic [7:0] lv [0:4] = '{8'h14, 8'h15, 8'h9f, 8'h20, 8'h00};
  logic [7:0] vol [0:3] = '{8'hc8, 8'hc9, 8'hff, 8'h00};
  int errors = 0, tests_run = 0, cyc = 0, i;
  ppc_power_ctrl_regs ppc_power_ctrl_regs_inst (.*);
  // clock and cycle ceiling
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      errors = errors + 1;
      conclude;
    end
  end
  task chk(input logic [7:0] act, input logic [7:0] exp);
    tests_run++;
    if (act !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  // one strobe cycle, answer settled after the taking edge
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 0;
    reg_rd <= 0;
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic h);
    acc(1, a, d);
    chk({7'h0, reg_hit}, {7'h0, h});
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    acc(0, a, 8'h00);
    chk(reg_rdata, e);
    chk({7'h0, reg_hit}, {7'h0, h});
  endtask
  task settle;
    @(posedge clk_sys);
    #1;
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 0;
    rd(8'h02, 8'h0e, 1);
    rd(8'h03, 8'h10, 1);
    rd(8'h04, 8'h01, 1);
    rd(8'h05, 8'h00, 1);
    chk(flags, 8'h39);
    chk({amp_level, highpass_corner}, 8'h81);
    chk({hpf_enable, pcm_vol_mute, pcm_atten[5:0]}, 8'h80);
    $display("test 1 done");
    for (i = 0; i < 4; i++) begin
      v = {4'h0, i[1:0], i[1:0]};
      wr(8'h02, v, 1);
      settle;
      chk(flags & 8'hf8, {i == 0, i == 1, i > 1, i[1], i[0], 3'h0});
      rd(8'h02, v, 1);
    end
    $display("test 2 done");
    wr(8'h04, 8'h03, 1);
    wr(8'h05, 8'hc9, 1);
    for (i = 0; i < 5; i++) begin
      v = lv[i];
      wr(8'h03, v, 1);
      settle;
      chk(flags & 8'h07, {5'h0, v[5], v[7], !v[7]});
      chk({3'h0, amp_level}, v[4:0] > 5'h14 ? 8'h14 : {3'h0, v[4:0]});
      chk({hpf_enable, pcm_vol_mute, 6'h0}, v[5] ? 8'h00 : 8'hc0);
      chk(pcm_atten, v[5] ? 8'h00 : 8'hc9);
    end
    $display("test 3 done");
    for (i = 0; i < 8; i++) begin
      v = i;
      wr(8'h04, v, 1);
      settle;
      chk({hpf_enable, 4'h0, highpass_corner}, {i != 0 && i != 7, 4'h0, v[2:0]});
    end
    for (i = 0; i < 4; i++) begin
      v = vol[i];
      wr(8'h05, v, 1);
      settle;
      chk({pcm_vol_mute, pcm_atten[6:0]}, {v > 8'hc8, v[6:0]});
      rd(8'h05, v, 1);
    end
    $display("test 4 done");
    wr(8'h00, 8'h01, 1);
    wr(8'h02, 8'h00, 0);
    rd(8'h02, 8'h00, 0);
    rd(8'h00, 8'h01, 1);
    wr(8'h00, 8'h00, 1);
    wr(8'h7f, 8'h02, 1);
    wr(8'h03, 8'h1f, 0);
    wr(8'h7f, 8'h00, 1);
    rd(8'h02, 8'h0f, 1);
    rd(8'h03, 8'h00, 1);
    rd(8'h01, 8'h00, 0);
    wr(8'h06, 8'hff, 0);
    rd(8'h06, 8'h00, 0);
    rd(8'h7e, 8'h00, 0);
    $display("test 5 done");
    // clock enable low: strobes ignored, answers held
    @(posedge clk_sys);
    clk_en <= 0;
    wr(8'h05, 8'h11, 0);
    rd(8'h02, 8'h00, 0);
    chk(pcm_atten, 8'h00);
    @(posedge clk_sys);
    clk_en <= 1;
    rd(8'h05, 8'h00, 1);
    chk(pcm_atten, 8'h00);
    $display("test 6 done");
    conclude;
  end
endmodule // tb_top
